// File: src/trail_pkg.sv
package trail_pkg;

  // ****************************************************************
  // frame layout
  // ****************************************************************
  localparam int unsigned FRAME_BITS  = 1536;
  localparam int unsigned POS_W       = 11;
  localparam int unsigned OH_BITS     = 12;
  localparam int unsigned FAS_LEN     = 10;
  localparam logic [9:0]  FAS_PATTERN = 10'h3d0;
  localparam logic [10:0] FAS_LAST    = 11'h009;
  localparam logic [10:0] RDI_POS     = 11'h00a;
  localparam logic [10:0] USER_POS    = 11'h00b;
  localparam logic [10:0] POS_LAST    = 11'h5ff;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] DEFECT_OFS    = 8'h04;
  localparam logic [7:0] EVENT_OFS     = 8'h08;
  localparam logic [7:0] MASK_OFS      = 8'h0c;
  localparam logic [7:0] COUNT_OFS     = 8'h10;

  // control fields
  localparam int unsigned CTRL_MODE_BIT  = 0;
  localparam int unsigned CTRL_RDI_EN    = 1;
  localparam int unsigned CTRL_SSF_EN    = 2;
  localparam int unsigned CTRL_PERS_LSB  = 4;
  localparam int unsigned PERS_W         = 4;
  localparam logic [7:0]  CTRL_RESET     = 8'h50;

  // event / mask bits
  localparam int unsigned EV_W        = 4;
  localparam int unsigned EV_BLOCK    = 0;
  localparam int unsigned EV_RDI_CHG  = 1;
  localparam int unsigned EV_SSF_RISE = 2;
  localparam int unsigned EV_SECOND   = 3;
  localparam logic [3:0]  EV_RESET    = 4'h0;
  localparam logic [3:0]  MASK_RESET  = 4'h0;

  // ****************************************************************
  // pin synchroniser slots
  // ****************************************************************
  localparam int unsigned NUM_SYNC  = 8;
  localparam int unsigned SY_SCLK   = 0;
  localparam int unsigned SY_SDATA  = 1;
  localparam int unsigned SY_SFS    = 2;
  localparam int unsigned SY_LCLK   = 3;
  localparam int unsigned SY_LDATA  = 4;
  localparam int unsigned SY_LFS    = 5;
  localparam int unsigned SY_SSF    = 6;
  localparam int unsigned SY_EQ     = 7;

  // co-directional bit stream: clock, data, frame start
  typedef struct packed {
    logic clk;
    logic data;
    logic fs;
  } stream_t;

  // register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

endpackage

// File: src/path_trail_termination_34m.sv
`timescale 1ns/10ps
// Contract
// - frame is 1536 bits, start marks bit one
// - first 12 bits overhead, rest payload
// - overhead: 10-bit word, defect bit, user bit
// - source overwrites word and defect bit, passes clock, data, start
// - source inserts alignment word 1111010000
// - source defect bit follows request within 800us
// - sink flags block errored on word mismatch
// - sink extracts received remote defect bit
// - trail fail output equals server fail input
// - defect request asserted while server fail
// - report remote defect if monitored and enabled
// - report server fail if monitored and enabled
// - far defect second if remote defect seen
// - count errored blocks, deliver each second
module path_trail_termination_34m #(
  parameter int unsigned EBC_W = 16
) (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  // source direction: from adaptation, toward line
  input  wire trail_pkg::stream_t src_in,
  output trail_pkg::stream_t      src_out,
  // sink direction: from line, toward adaptation
  input  wire trail_pkg::stream_t line_in,
  input  wire logic               server_fail_in,
  output trail_pkg::stream_t      payload_out,
  output logic                    trail_fail_out,
  output logic                    remote_defect_request,
  // management
  input  wire logic               one_second_tick,
  input  wire logic               equipment_defect,
  output logic                    remote_defect_reported,
  output logic                    server_fail_reported,
  output logic                    near_defect_second,
  output logic                    far_defect_second,
  output logic [EBC_W-1:0]        near_errored_block_count,
  // register port
  input  wire trail_pkg::reg_req_t reg_req,
  output logic [31:0]             reg_rdata,
  output logic                    irq
);
  import trail_pkg::*;

  if (EBC_W < 16 || EBC_W > 32) begin : g_bad_width
    $error("EBC_W must lie between 16 and 32");
  end

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [NUM_SYNC-1:0] pin_raw;
  logic [NUM_SYNC-1:0] pin_meta;
  logic [NUM_SYNC-1:0] pin_sync;
  logic [NUM_SYNC-1:0] pin_prev;

  assign pin_raw = {equipment_defect, server_fail_in, line_in.fs, line_in.data,
                    line_in.clk, src_in.fs, src_in.data, src_in.clk};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SYNC; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
          pin_prev[gi] <= 1'b0;
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
          pin_prev[gi] <= pin_sync[gi];
        end
      end
    end
  endgenerate

  wire src_rise  = pin_sync[SY_SCLK] & ~pin_prev[SY_SCLK];
  wire line_rise = pin_sync[SY_LCLK] & ~pin_prev[SY_LCLK];
  wire ssf       = pin_sync[SY_SSF];
  wire eq_def    = pin_sync[SY_EQ];

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0]       ctrl;
  logic [EV_W-1:0]  ev_status;
  logic [EV_W-1:0]  ev_mask;
  logic [EV_W-1:0]  ev_now;
  logic             rdi_detected;

  wire wr_ctrl  = reg_req.wr && (reg_req.addr == CTRL_OFS);
  wire wr_event = reg_req.wr && (reg_req.addr == EVENT_OFS);
  wire wr_mask  = reg_req.wr && (reg_req.addr == MASK_OFS);

  wire monitor_active = ctrl[CTRL_MODE_BIT];
  wire rdi_report_en  = ctrl[CTRL_RDI_EN];
  wire ssf_report_en  = ctrl[CTRL_SSF_EN];
  wire [PERS_W-1:0] persist_cfg = ctrl[CTRL_PERS_LSB +: PERS_W];
  wire [PERS_W-1:0] persist = (persist_cfg == 4'h0) ? 4'h1 : persist_cfg;

  logic [31:0] rd_mux;
  wire [EV_W-1:0] next_ev_status = (ev_status & ~(wr_event ? reg_req.wdata[EV_W-1:0] :
                                    4'h0)) | ev_now;

  always_comb begin
    rd_mux = 32'h0;
    if (reg_req.addr == CTRL_OFS) begin
      rd_mux = {24'h0, ctrl};
    end else if (reg_req.addr == DEFECT_OFS) begin
      rd_mux = {28'h0, eq_def, ssf, rdi_detected, monitor_active};
    end else if (reg_req.addr == EVENT_OFS) begin
      rd_mux = {28'h0, ev_status};
    end else if (reg_req.addr == MASK_OFS) begin
      rd_mux = {28'h0, ev_mask};
    end else if (reg_req.addr == COUNT_OFS) begin
      rd_mux = 32'(near_errored_block_count);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl      <= CTRL_RESET;
      ev_status <= EV_RESET;
      ev_mask   <= MASK_RESET;
      reg_rdata <= 32'h0;
      irq       <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= reg_req.wdata[7:0];
      end
      if (wr_mask) begin
        ev_mask <= reg_req.wdata[EV_W-1:0];
      end
      ev_status <= next_ev_status;
      reg_rdata <= reg_req.rd ? rd_mux : 32'h0;
      irq       <= |(next_ev_status & ev_mask);
    end
  end

  // ****************************************************************
  // source: overhead insertion
  // ****************************************************************
  logic [POS_W-1:0] src_pos;
  wire  [POS_W-1:0] next_src_pos = pin_sync[SY_SFS] ? 11'h000 :
                                   (src_pos == POS_LAST) ? 11'h000 : src_pos + 11'h001;
  wire  [3:0] src_fas_idx = 4'(FAS_LEN - 1) - next_src_pos[3:0];
  logic src_bit;

  always_comb begin
    src_bit = pin_sync[SY_SDATA];
    if (next_src_pos <= FAS_LAST) begin
      src_bit = FAS_PATTERN[src_fas_idx];
    end else if (next_src_pos == RDI_POS) begin
      src_bit = remote_defect_request;
    end
  end

  // the user bit at USER_POS passes through untouched
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      src_pos <= POS_LAST;
      src_out <= '0;
    end else begin
      src_out.clk <= pin_prev[SY_SCLK];
      if (src_rise) begin
        src_pos      <= next_src_pos;
        src_out.data <= src_bit;
        src_out.fs   <= pin_sync[SY_SFS];
      end
    end
  end

  // ****************************************************************
  // sink: alignment check and defect bit extraction
  // ****************************************************************
  logic [POS_W-1:0] line_pos;
  logic             line_framed;
  logic             fas_mismatch;
  logic             block_pulse;
  logic             block_bad;
  logic             rdi_pulse;
  logic             rdi_rx;
  logic [PERS_W-1:0] rdi_run;

  wire [POS_W-1:0] next_line_pos = pin_sync[SY_LFS] ? 11'h000 :
                                   (line_pos == POS_LAST) ? 11'h000 : line_pos + 11'h001;
  wire [3:0] line_fas_idx = 4'(FAS_LEN - 1) - next_line_pos[3:0];
  wire line_bit = pin_sync[SY_LDATA];
  wire fas_bit_bad = (next_line_pos <= FAS_LAST) &&
                     (line_bit != FAS_PATTERN[line_fas_idx]);
  wire frame_err = ((next_line_pos == 11'h000) ? 1'b0 : fas_mismatch) | fas_bit_bad;
  wire line_framing = line_framed | pin_sync[SY_LFS];

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      line_pos     <= POS_LAST;
      line_framed  <= 1'b0;
      fas_mismatch <= 1'b0;
      block_pulse  <= 1'b0;
      block_bad    <= 1'b0;
      rdi_pulse    <= 1'b0;
      rdi_rx       <= 1'b0;
      payload_out  <= '0;
    end else begin
      payload_out.clk <= pin_prev[SY_LCLK];
      block_pulse     <= 1'b0;
      rdi_pulse       <= 1'b0;
      if (line_rise) begin
        line_pos         <= next_line_pos;
        line_framed      <= line_framing;
        fas_mismatch     <= frame_err;
        payload_out.data <= line_bit;
        payload_out.fs   <= pin_sync[SY_LFS];
        if (line_framing && next_line_pos == FAS_LAST) begin
          block_pulse <= 1'b1;
          block_bad   <= frame_err;
        end
        if (line_framing && next_line_pos == RDI_POS) begin
          rdi_pulse <= 1'b1;
          rdi_rx    <= line_bit;
        end
      end
    end
  end

  // persistence filter on the received defect bit
  wire [PERS_W-1:0] rdi_run_inc = rdi_run + 4'h1;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdi_run      <= 4'h0;
      rdi_detected <= 1'b0;
    end else if (rdi_pulse) begin
      if (rdi_rx == rdi_detected) begin
        rdi_run <= 4'h0;
      end else if (rdi_run_inc >= persist) begin
        rdi_run      <= 4'h0;
        rdi_detected <= rdi_rx;
      end else begin
        rdi_run <= rdi_run_inc;
      end
    end
  end

  // ****************************************************************
  // consequent actions and correlations
  // ****************************************************************
  logic ssf_prev;
  logic rdi_prev;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      trail_fail_out         <= 1'b0;
      remote_defect_request  <= 1'b0;
      remote_defect_reported <= 1'b0;
      server_fail_reported   <= 1'b0;
      ssf_prev               <= 1'b0;
      rdi_prev               <= 1'b0;
    end else begin
      trail_fail_out         <= ssf;
      remote_defect_request  <= ssf;
      remote_defect_reported <= rdi_detected & monitor_active & rdi_report_en;
      server_fail_reported   <= ssf & monitor_active & ssf_report_en;
      ssf_prev               <= ssf;
      rdi_prev               <= rdi_detected;
    end
  end

  // ****************************************************************
  // one-second performance primitives
  // ****************************************************************
  logic             far_seen;
  logic             near_seen;
  logic [EBC_W-1:0] ebc_acc;

  wire             block_inc = block_pulse & block_bad;
  wire             ebc_full  = &ebc_acc;
  wire [EBC_W-1:0] ebc_sum   = ebc_acc + ((block_inc && !ebc_full) ? EBC_W'(1) : EBC_W'(0));
  wire             near_now  = ssf | eq_def;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      far_seen                 <= 1'b0;
      near_seen                <= 1'b0;
      ebc_acc                  <= '0;
      far_defect_second        <= 1'b0;
      near_defect_second       <= 1'b0;
      near_errored_block_count <= '0;
    end else if (one_second_tick) begin
      far_defect_second        <= far_seen | rdi_detected;
      near_defect_second       <= near_seen | near_now;
      near_errored_block_count <= ebc_sum;
      far_seen                 <= rdi_detected;
      near_seen                <= near_now;
      ebc_acc                  <= '0;
    end else begin
      far_seen  <= far_seen | rdi_detected;
      near_seen <= near_seen | near_now;
      ebc_acc   <= ebc_sum;
    end
  end

  // note: a block that errs in the tick cycle is counted in the closing interval
  assign ev_now[EV_BLOCK]    = block_inc;
  assign ev_now[EV_RDI_CHG]  = rdi_detected ^ rdi_prev;
  assign ev_now[EV_SSF_RISE] = ssf & ~ssf_prev;
  assign ev_now[EV_SECOND]   = one_second_tick;

endmodule

// File: testbench/trail_monitor.sv
`timescale 1ns/10ps
module trail_monitor #(
  parameter int unsigned EBC_W = 16
) (
  // clock and reset
  input wire logic                 core_clk,
  input wire logic                 sys_rst,
  // streams
  input wire trail_pkg::stream_t   src_in,
  input wire trail_pkg::stream_t   src_out,
  input wire trail_pkg::stream_t   line_in,
  input wire trail_pkg::stream_t   payload_out,
  // fail and reports
  input wire logic                 server_fail_in,
  input wire logic                 trail_fail_out,
  input wire logic                 remote_defect_request,
  input wire logic                 remote_defect_reported,
  input wire logic                 server_fail_reported,
  // management
  input wire logic                 one_second_tick,
  input wire logic                 near_defect_second,
  input wire logic                 far_defect_second,
  input wire logic [EBC_W-1:0]     near_errored_block_count,
  input wire trail_pkg::reg_req_t  reg_req,
  input wire logic [31:0]          reg_rdata
);
  import trail_pkg::*;
  // ****
  // properties
  // ****
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  a_fail_follows: assert property (server_fail_in [*6] |-> trail_fail_out)
    else $error("trail fail not following server fail");
  a_request_match: assert property (server_fail_in [*6] |-> remote_defect_request)
    else $error("defect request not raised on server fail");
  a_request_clear: assert property (!server_fail_in [*6] |-> !remote_defect_request)
    else $error("defect request without server fail");
  a_ssf_report: assert property (!server_fail_in [*6] |-> !server_fail_reported)
    else $error("server fail reported without cause");
  a_mode_off: assert property (reg_req.wr && reg_req.addr == CTRL_OFS &&
      !reg_req.wdata[CTRL_MODE_BIT] |-> ##3 !remote_defect_reported && !server_fail_reported)
    else $error("report while not monitored");
  a_count_hold: assert property (!one_second_tick |=> $stable(near_errored_block_count))
    else $error("block count changed off tick");
  a_far_hold: assert property (!one_second_tick |=> $stable(far_defect_second))
    else $error("far defect second changed off tick");
  a_word_start: assert property ($rose(src_out.clk) && src_out.fs |-> src_out.data)
    else $error("frame start bit not one");
  a_src_pass: assert property ($rose(src_in.clk) |-> ##[1:8] $rose(src_out.clk))
    else $error("source clock not passed");
  a_sink_pass: assert property ($rose(line_in.clk) |-> ##[1:8] $rose(payload_out.clk))
    else $error("sink clock not passed");
  a_rdata_idle: assert property (!$past(reg_req.rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read answer");
  c_rdi: cover property ($rose(remote_defect_reported));
  c_ssf: cover property ($rose(server_fail_reported));
  c_count: cover property (one_second_tick ##1 near_errored_block_count != 0);
endmodule

bind path_trail_termination_34m trail_monitor #(.EBC_W(EBC_W)) u_mon (
  .core_clk, .sys_rst, .src_in, .src_out, .line_in, .payload_out, .server_fail_in,
  .trail_fail_out, .remote_defect_request, .remote_defect_reported, .server_fail_reported,
  .one_second_tick, .near_defect_second, .far_defect_second, .near_errored_block_count,
  .reg_req, .reg_rdata);

// File: testbench/far_end_line.sv
`timescale 1ns/10ps
module far_end_line (
  // control
  input wire logic [2:0]     bad,
  input wire logic [2:0]     remote_defect_bit,
  input wire logic           go,
  // line toward the sink
  output trail_pkg::stream_t line
);
  import trail_pkg::*;
  logic [9:0] w;
  // ****
  // three frames, clock still outside them
  // ****
  initial begin
    line = '0;
    @(posedge go);
    for (int f = 0; f < 3; f++) begin
      w = FAS_PATTERN ^ {9'h0, bad[f]};
      for (int p = 0; p < FRAME_BITS; p++) begin
        line.fs = (p == 0);
        if (p < FAS_LEN)
          line.data = w[FAS_LEN - 1 - p];
        else if (p == RDI_POS)
          line.data = remote_defect_bit[f];
        else
          line.data = 1'($urandom_range(1, 0));
        #62.5 line.clk = 1'b1;
        #62.5 line.clk = 1'b0;
      end
    end
    line.data = ~line.data;
  end
endmodule

// File: testbench/test_path_trail_termination_34m.sv
`timescale 1ns/10ps
module test_path_trail_termination_34m;
  import trail_pkg::*;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  stream_t     src_in = '0;
  logic        server_fail_in = 1'b0;
  logic        one_second_tick = 1'b0;
  reg_req_t    reg_req = '0;
  logic        go = 1'b0;
  logic        rd_d = 1'b0;
  logic        tick_d = 1'b0;
  logic        oclk_d = 1'b0;
  logic        lclk_d = 1'b0;
  logic        pclk_d = 1'b0;
  logic        equipment_defect = 1'b0;
  logic [1:0]  lq[$];
  stream_t     line_in;
  stream_t     src_out;
  stream_t     payload_out;
  logic        trail_fail_out;
  logic        remote_defect_request;
  logic        remote_defect_reported;
  logic        server_fail_reported;
  logic        near_defect_second;
  logic        far_defect_second;
  logic        irq;
  logic [15:0] near_errored_block_count;
  logic [31:0] reg_rdata;
  logic [31:0] rq[$];
  logic [31:0] tq[$];
  logic [1:0]  sq[$];
  int          n_errors = 0;
  int          total_checks = 0;

  always #5 core_clk = ~core_clk;

  path_trail_termination_34m DUT (.core_clk, .sys_rst, .src_in, .src_out, .line_in,
    .server_fail_in, .payload_out, .trail_fail_out, .remote_defect_request,
    .one_second_tick, .equipment_defect, .remote_defect_reported,
    .server_fail_reported, .near_defect_second, .far_defect_second,
    .near_errored_block_count, .reg_req, .reg_rdata, .irq);

  far_end_line u_far (.bad(3'b110), .remote_defect_bit(3'b010), .go, .line(line_in));

  // ****
  // tasks
  // ****
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    reg_req <= '0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    reg_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge core_clk);
    reg_req <= '0;
    @(posedge core_clk);
  endtask

  task automatic tick(input logic [31:0] e);
    tq.push_back(e);
    one_second_tick <= 1'b1;
    @(posedge core_clk);
    one_second_tick <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(posedge core_clk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  task automatic src_frames();
    logic b;
    for (int f = 0; f < 3; f++) begin
      server_fail_in <= (f == 1);
      for (int p = 0; p < FRAME_BITS; p++) begin
        if (p == 20)
          chk("fail", {28'h0, {4{f == 1}}},
            {28'h0, trail_fail_out, remote_defect_request, server_fail_reported,
             remote_defect_reported});
        b = 1'($urandom_range(1, 0));
        src_in.data <= b;
        src_in.fs <= (p == 0);
        if (p < FAS_LEN)
          sq.push_back({p == 0, FAS_PATTERN[FAS_LEN - 1 - p]});
        else if (p == RDI_POS)
          sq.push_back({1'b0, f == 1});
        else
          sq.push_back({1'b0, b});
        repeat (6) @(posedge core_clk);
        src_in.clk <= 1'b1;
        repeat (6 + p % 2) @(posedge core_clk);
        src_in.clk <= 1'b0;
      end
    end
    server_fail_in <= 1'b0;
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ****
  // output watcher
  // ****
  always @(posedge core_clk) begin
    if (rd_d && rq.size() > 0)
      chk("reg_rdata", rq.pop_front(), reg_rdata);
    if (tick_d && tq.size() > 0)
      chk("second", tq.pop_front(), {14'h0, near_defect_second, far_defect_second,
        near_errored_block_count});
    if (src_out.clk && !oclk_d && sq.size() > 0)
      chk("src_out", {30'h0, sq.pop_front()}, {30'h0, src_out.fs, src_out.data});
    if (line_in.clk && !lclk_d)
      lq.push_back({line_in.fs, line_in.data});
    if (payload_out.clk && !pclk_d && lq.size() > 0)
      chk("payload_out", {30'h0, lq.pop_front()},
        {30'h0, payload_out.fs, payload_out.data});
    rd_d <= reg_req.rd;
    tick_d <= one_second_tick;
    oclk_d <= src_out.clk;
    lclk_d <= line_in.clk;
    pclk_d <= payload_out.clk;
  end

  initial begin
    repeat (90000) @(posedge core_clk);
    n_errors++;
    print_verdict();
  end

  // ****
  // main sequence
  // ****
  initial begin
    void'($urandom(69));
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rd(CTRL_OFS, {24'h0, CTRL_RESET});
    rd(MASK_OFS, {28'h0, MASK_RESET});
    rd(EVENT_OFS, {28'h0, EV_RESET});
    wr(8'h14, 32'hffffffff);
    rd(8'h14, 32'h0);
    wr(CTRL_OFS, 32'h17);
    wr(MASK_OFS, 32'h1);
    go <= 1'b1;
    src_frames();
    repeat (200) @(posedge core_clk);
    tick({14'h0, 1'b1, 1'b1, 16'h2});
    equipment_defect <= 1'b1;
    rd(COUNT_OFS, 32'h2);
    rd(EVENT_OFS, 32'hf);
    rd(DEFECT_OFS, 32'h9);
    irq_is(1'b1);
    wr(MASK_OFS, 32'h0);
    irq_is(1'b0);
    wr(MASK_OFS, 32'h1);
    irq_is(1'b1);
    wr(EVENT_OFS, 32'hf);
    irq_is(1'b0);
    server_fail_in <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk("ssf_on", 32'h1, {31'h0, server_fail_reported});
    wr(CTRL_OFS, 32'h16);
    repeat (4) @(posedge core_clk);
    chk("ssf_off", 32'h2, {30'h0, trail_fail_out, server_fail_reported});
    tick({14'h0, 1'b1, 1'b0, 16'h0});
    chk("src_left", 32'h0, sq.size());
    chk("line_left", 32'h0, lq.size());
    print_verdict();
  end
endmodule
